// >>> rtl/canbrr_pkg.sv
/*
 * Constants, register map and types of the CAN remote-reply engine and its bit timer.
 * Assumes a single 10 MHz module clock and an APB master with 32-bit data.
 */
package canbrr_pkg;

    localparam int          NUM_BUF     = 15;
    localparam int          BASIC_BUF   = 14;
    localparam int          ADDR_W      = 8;

    localparam logic [7:0]  ADDR_CTRL   = 8'h00;
    localparam logic [7:0]  ADDR_TIMING = 8'h04;
    localparam logic [7:0]  ADDR_GMASK  = 8'h08;
    localparam logic [7:0]  ADDR_BMASK  = 8'h0c;
    localparam logic [7:0]  ADDR_STATUS = 8'h10;
    localparam logic [1:0]  REGION_ID   = 2'h1;
    localparam logic [1:0]  REGION_ST   = 2'h2;
    localparam logic [1:0]  REGION_CFG  = 2'h0;

    localparam int          CTRL_EN_POS    = 0;
    localparam int          CTRL_LOOP_POS  = 1;
    localparam int          TIM_PSC_LSB    = 0;
    localparam int          TIM_SEG1_LSB   = 6;
    localparam int          TIM_SEG2_LSB   = 10;
    localparam int          STAT_BUSY_POS  = 0;
    localparam int          STAT_LATE_POS  = 1;
    localparam int          STAT_LASTTX_LSB = 4;
    localparam int          OBJ_RTR_POS    = 0;

    localparam logic [31:0] MASK_RST    = 32'h0000_0000;
    localparam logic [31:0] ID_RST      = 32'h0000_0000;
    localparam logic [5:0]  PSC_RST     = 6'h00;
    localparam logic [3:0]  SEG1_RST    = 4'h1;
    localparam logic [2:0]  SEG2_RST    = 3'h0;

    localparam logic [4:0]  COPY_CYCLES   = 5'd17;
    localparam logic [4:0]  UPDATE_CYCLES = 5'd3;
    localparam logic [4:0]  SCHED_CYCLES  = 5'd2;
    localparam logic [2:0]  GAP_BITS      = 3'd4;

    localparam logic [6:0]  PSC_OFFSET  = 7'd2;
    localparam logic [4:0]  SEG1_OFFSET = 5'd1;
    localparam logic [4:0]  SEG2_OFFSET = 5'd1;
    localparam logic [4:0]  SYNC_QUANTA = 5'd1;

    typedef enum logic [2:0] {
        BUF_OFF,
        BUF_RX_EMPTY,
        BUF_RX_FULL,
        BUF_TX_DATA,
        BUF_REPLY_ARMED,
        BUF_REPLY_SINGLE
    } canbrr_buf_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_COPY,
        ST_UPDATE,
        ST_SCHED
    } canbrr_state_t;

endpackage

// >>> rtl/canbrr_bit_timer.sv
/*
 * Bit time logic: divides the module clock into time quanta and marks sample point and bit end.
 * Assumes the timing fields are stable while enable is high.
 */
`timescale 1ns/1ps
module canbrr_bit_timer
    import canbrr_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rstn_in,
    input  wire logic       enable_in,
    input  wire logic [5:0] psc_field_in,
    input  wire logic [3:0] seg1_field_in,
    input  wire logic [2:0] seg2_field_in,
    output logic            sample_tick_out,
    output logic            bit_tick_out
);

    logic [6:0] psc_eff;
    logic [4:0] seg1_eff;
    logic [4:0] seg2_eff;
    logic [4:0] quanta;
    logic [6:0] pre_cnt;
    logic [6:0] next_pre_cnt;
    logic [4:0] q_cnt;
    logic [4:0] next_q_cnt;
    logic       tq;
    logic       next_sample;
    logic       next_bit;

    always_comb begin
        psc_eff  = {1'b0, psc_field_in} + PSC_OFFSET;
        seg1_eff = {1'b0, seg1_field_in} + SEG1_OFFSET;
        seg2_eff = {2'b00, seg2_field_in} + SEG2_OFFSET;
        quanta   = SYNC_QUANTA + seg1_eff + seg2_eff;
        tq       = enable_in && (pre_cnt == psc_eff - 7'd1);
        next_pre_cnt = (!enable_in || tq) ? 7'd0 : pre_cnt + 7'd1;
        next_q_cnt   = q_cnt;
        if (!enable_in) begin
            next_q_cnt = 5'd0;
        end else if (tq) begin
            next_q_cnt = (q_cnt == quanta - 5'd1) ? 5'd0 : q_cnt + 5'd1;
        end
        next_sample = tq && (q_cnt == seg1_eff);
        next_bit    = tq && (q_cnt == quanta - 5'd1);
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pre_cnt         <= 7'h00;
            q_cnt           <= 5'h00;
            sample_tick_out <= 1'b0;
            bit_tick_out    <= 1'b0;
        end else begin
            pre_cnt         <= next_pre_cnt;
            q_cnt           <= next_q_cnt;
            sample_tick_out <= next_sample;
            bit_tick_out    <= next_bit;
        end
    end

endmodule // canbrr_bit_timer

// >>> rtl/canbrr_top.sv
/*
 * CAN post-frame engine: acceptance filtering, hidden-buffer copy, remote reply handling,
 * transmission scheduling, bit timing and the APB register file.
 * Assumes a protocol engine that pulses FRAME_VALID_IN at the frame validation point.
 */
`timescale 1ns/1ps
module canbrr_top
    import canbrr_pkg::*;
(
    input  wire logic        CLK_IN,
    input  wire logic        RSTN_IN,
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [7:0]  PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic             PREADY_OUT,
    output logic [31:0]      PRDATA_OUT,
    output logic             PSLVERR_OUT,
    input  wire logic        FRAME_VALID_IN,
    input  wire logic        FRAME_OWN_IN,
    input  wire logic [31:0] FRAME_OBJ_IN,
    output logic             TX_REQ_OUT,
    output logic [3:0]       TX_BUF_OUT,
    output logic [31:0]      TX_OBJ_OUT,
    output logic             SAMPLE_TICK_OUT,
    output logic             BIT_TICK_OUT,
    output logic             BUSY_OUT
);

    logic                ctrl_en, next_ctrl_en;
    logic                ctrl_loop, next_ctrl_loop;
    logic [5:0]          tim_psc, next_tim_psc;
    logic [3:0]          tim_seg1, next_tim_seg1;
    logic [2:0]          tim_seg2, next_tim_seg2;
    logic [31:0]         gmask, next_gmask;
    logic [31:0]         bmask, next_bmask;
    logic [31:0]         next_prdata;
    logic                next_pready;
    logic                next_pslverr;
    logic                apb_setup;
    logic                apb_write;
    logic                buf_region;
    logic                mapped;
    logic [3:0]          addr_idx;
    logic                wr_id, wr_st, late_clr;

    logic [31:0]         buf_id [NUM_BUF];
    logic [31:0]         next_buf_id [NUM_BUF];
    canbrr_buf_t         buf_state [NUM_BUF];
    canbrr_buf_t         next_buf_state [NUM_BUF];
    canbrr_state_t       state, next_state;
    logic [4:0]          cnt, next_cnt;
    logic [31:0]         obj, next_obj;
    logic [3:0]          copy_sel, next_copy_sel;
    logic [NUM_BUF-1:0]  pending, next_pending;
    logic                sched_valid, next_sched_valid;
    logic [3:0]          sched_buf, next_sched_buf;
    logic [2:0]          gap, next_gap;
    logic                late, next_late;
    logic [3:0]          last_tx, next_last_tx;
    logic                echo_valid, next_echo_valid;
    logic [31:0]         echo_obj, next_echo_obj;
    logic                next_tx_req;
    logic [3:0]          next_tx_buf;
    logic [31:0]         next_tx_obj;
    logic                next_busy;
    logic                stall;
    logic [NUM_BUF-1:0]  rx_hit;
    logic [NUM_BUF-1:0]  reply_hit;
    logic                accept;
    logic [3:0]          upd_sel;

    function automatic logic [3:0] first_set(input logic [NUM_BUF-1:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = NUM_BUF - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    canbrr_bit_timer u_bit_timer (
        .clk_in          (CLK_IN),
        .rstn_in         (RSTN_IN),
        .enable_in       (ctrl_en),
        .psc_field_in    (tim_psc),
        .seg1_field_in   (tim_seg1),
        .seg2_field_in   (tim_seg2),
        .sample_tick_out (SAMPLE_TICK_OUT),
        .bit_tick_out    (BIT_TICK_OUT)
    );

    // Per-buffer acceptance comparison; the last buffer uses the basic mask.
    genvar g;
    for (g = 0; g < NUM_BUF; g++) begin : g_match
        logic [31:0] care;
        assign care = ~((g == BASIC_BUF) ? bmask : gmask);
        assign rx_hit[g] = (buf_state[g] == BUF_RX_EMPTY) && (((FRAME_OBJ_IN ^ buf_id[g]) & care) == 32'h0);
        assign reply_hit[g] = (buf_state[g] == BUF_REPLY_ARMED) && FRAME_OBJ_IN[OBJ_RTR_POS]
                              && (((FRAME_OBJ_IN ^ buf_id[g]) & care) == 32'h0);
    end

    // APB decode and configuration registers.
    always_comb begin
        apb_setup  = PSEL_IN && !PENABLE_IN;
        apb_write  = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN;
        addr_idx   = PADDR_IN[5:2];
        buf_region = (PADDR_IN[7:6] == REGION_ID) || (PADDR_IN[7:6] == REGION_ST);
        mapped     = (buf_region && (addr_idx < 4'(NUM_BUF)) && (PADDR_IN[1:0] == 2'b00))
                     || (PADDR_IN == ADDR_CTRL) || (PADDR_IN == ADDR_TIMING) || (PADDR_IN == ADDR_GMASK)
                     || (PADDR_IN == ADDR_BMASK) || (PADDR_IN == ADDR_STATUS);
        wr_id    = apb_write && mapped && (PADDR_IN[7:6] == REGION_ID);
        wr_st    = apb_write && mapped && (PADDR_IN[7:6] == REGION_ST);
        late_clr = apb_write && (PADDR_IN == ADDR_STATUS) && PWDATA_IN[STAT_LATE_POS];
        next_ctrl_en   = ctrl_en;
        next_ctrl_loop = ctrl_loop;
        next_tim_psc   = tim_psc;
        next_tim_seg1  = tim_seg1;
        next_tim_seg2  = tim_seg2;
        next_gmask     = gmask;
        next_bmask     = bmask;
        if (apb_write) begin
            case (PADDR_IN)
                ADDR_CTRL: begin
                    next_ctrl_en   = PWDATA_IN[CTRL_EN_POS];
                    next_ctrl_loop = PWDATA_IN[CTRL_LOOP_POS];
                end
                ADDR_TIMING: begin
                    next_tim_psc  = PWDATA_IN[TIM_PSC_LSB +: 6];
                    next_tim_seg1 = PWDATA_IN[TIM_SEG1_LSB +: 4];
                    next_tim_seg2 = PWDATA_IN[TIM_SEG2_LSB +: 3];
                end
                ADDR_GMASK: next_gmask = PWDATA_IN;
                ADDR_BMASK: next_bmask = PWDATA_IN;
                default: ;
            endcase
        end
        next_pready  = apb_setup;
        next_pslverr = apb_setup && !mapped;
        next_prdata  = 32'h0;
        if (apb_setup && !PWRITE_IN && mapped) begin
            if (PADDR_IN[7:6] == REGION_ID) begin
                next_prdata = buf_id[addr_idx];
            end else if (PADDR_IN[7:6] == REGION_ST) begin
                next_prdata = {29'h0, buf_state[addr_idx]};
            end else begin
                case (PADDR_IN)
                    ADDR_CTRL: begin
                        next_prdata[CTRL_EN_POS]   = ctrl_en;
                        next_prdata[CTRL_LOOP_POS] = ctrl_loop;
                    end
                    ADDR_TIMING: begin
                        next_prdata[TIM_PSC_LSB +: 6]  = tim_psc;
                        next_prdata[TIM_SEG1_LSB +: 4] = tim_seg1;
                        next_prdata[TIM_SEG2_LSB +: 3] = tim_seg2;
                    end
                    ADDR_GMASK: next_prdata = gmask;
                    ADDR_BMASK: next_prdata = bmask;
                    ADDR_STATUS: begin
                        next_prdata[STAT_BUSY_POS]        = BUSY_OUT;
                        next_prdata[STAT_LATE_POS]        = late;
                        next_prdata[STAT_LASTTX_LSB +: 4] = last_tx;
                    end
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            ctrl_en     <= 1'b0;
            ctrl_loop   <= 1'b0;
            tim_psc     <= PSC_RST;
            tim_seg1    <= SEG1_RST;
            tim_seg2    <= SEG2_RST;
            gmask       <= MASK_RST;
            bmask       <= MASK_RST;
            PREADY_OUT  <= 1'b0;
            PSLVERR_OUT <= 1'b0;
            PRDATA_OUT  <= 32'h0;
        end else begin
            ctrl_en     <= next_ctrl_en;
            ctrl_loop   <= next_ctrl_loop;
            tim_psc     <= next_tim_psc;
            tim_seg1    <= next_tim_seg1;
            tim_seg2    <= next_tim_seg2;
            gmask       <= next_gmask;
            bmask       <= next_bmask;
            PREADY_OUT  <= next_pready;
            PSLVERR_OUT <= next_pslverr;
            PRDATA_OUT  <= next_prdata;
        end
    end

    // Frame processing engine and message buffers.
    always_comb begin
        logic [31:0] reply_obj;
        reply_obj = 32'h0;
        stall = PSEL_IN && buf_region;
        // own frame accepted after shared identifier
        accept = !FRAME_OWN_IN || ctrl_loop || (echo_valid && (FRAME_OBJ_IN == echo_obj));
        upd_sel          = first_set(pending);
        next_state       = state;
        next_cnt         = cnt;
        next_obj         = obj;
        next_copy_sel    = copy_sel;
        next_pending     = pending;
        next_sched_valid = sched_valid;
        next_sched_buf   = sched_buf;
        next_gap         = gap;
        next_last_tx     = last_tx;
        next_echo_valid  = echo_valid;
        next_echo_obj    = echo_obj;
        next_tx_req      = 1'b0;
        next_tx_buf      = TX_BUF_OUT;
        next_tx_obj      = TX_OBJ_OUT;
        next_late        = late && !late_clr;
        for (int i = 0; i < NUM_BUF; i++) begin
            next_buf_id[i]    = buf_id[i];
            next_buf_state[i] = buf_state[i];
        end
        if (wr_id) begin
            next_buf_id[addr_idx] = PWDATA_IN;
        end
        if (wr_st) begin
            next_buf_state[addr_idx] = canbrr_buf_t'(PWDATA_IN[2:0]);
        end
        if (state != ST_IDLE && BIT_TICK_OUT) begin
            next_gap = gap + 3'd1;
            if (gap == GAP_BITS - 3'd1) begin
                next_late = 1'b1;
            end
        end
        case (state)
            ST_IDLE: begin
                if (FRAME_VALID_IN && ctrl_en) begin
                    next_obj         = FRAME_OBJ_IN;
                    next_gap         = 3'd0;
                    next_sched_valid = 1'b0;
                    next_pending     = accept ? reply_hit : '0;
                    if (FRAME_OBJ_IN != echo_obj) begin
                        next_echo_valid = 1'b0;
                    end
                    if (accept && !FRAME_OWN_IN && (rx_hit != '0)) begin
                        next_echo_valid = 1'b1;
                        next_echo_obj   = FRAME_OBJ_IN;
                    end
                    if (accept && (rx_hit != '0)) begin
                        next_copy_sel = first_set(rx_hit);
                        next_state    = ST_COPY;
                        next_cnt      = COPY_CYCLES - 5'd1;
                    end else if (accept && (reply_hit != '0)) begin
                        next_state = ST_UPDATE;
                        next_cnt   = UPDATE_CYCLES - 5'd1;
                    end
                end
            end
            ST_COPY: begin
                if (!stall) begin
                    next_cnt = cnt - 5'd1;
                    if (cnt == 5'd0) begin
                        next_buf_id[copy_sel]    = obj;
                        next_buf_state[copy_sel] = BUF_RX_FULL;
                        next_state = (pending != '0) ? ST_UPDATE : ST_IDLE;
                        next_cnt   = UPDATE_CYCLES - 5'd1;
                    end
                end
            end
            ST_UPDATE: begin
                if (!stall) begin
                    next_cnt = cnt - 5'd1;
                    if (cnt == 5'd0) begin
                        next_buf_state[upd_sel] = BUF_REPLY_SINGLE;
                        next_pending[upd_sel]   = 1'b0;
                        if (!sched_valid) begin
                            next_sched_valid = 1'b1;
                            next_sched_buf   = upd_sel;
                        end
                        if ((pending & ~(15'h1 << upd_sel)) != '0) begin
                            next_cnt = UPDATE_CYCLES - 5'd1;
                        end else begin
                            next_state = ST_SCHED;
                            next_cnt   = SCHED_CYCLES - 5'd1;
                        end
                    end
                end
            end
            ST_SCHED: begin
                if (!stall) begin
                    next_cnt = cnt - 5'd1;
                    if (cnt == 5'd0) begin
                        // reply sent with remote bit clear
                        reply_obj              = buf_id[sched_buf];
                        reply_obj[OBJ_RTR_POS] = 1'b0;
                        next_tx_req  = 1'b1;
                        next_tx_buf  = sched_buf;
                        next_tx_obj  = reply_obj;
                        next_last_tx = sched_buf;
                        next_state   = ST_IDLE;
                    end
                end
            end
            default: next_state = ST_IDLE;
        endcase
        next_busy = (next_state != ST_IDLE);
    end

    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            state       <= ST_IDLE;
            cnt         <= 5'h00;
            obj         <= 32'h0;
            copy_sel    <= 4'h0;
            pending     <= '0;
            sched_valid <= 1'b0;
            sched_buf   <= 4'h0;
            gap         <= 3'h0;
            late        <= 1'b0;
            last_tx     <= 4'h0;
            echo_valid  <= 1'b0;
            echo_obj    <= 32'h0;
            TX_REQ_OUT  <= 1'b0;
            TX_BUF_OUT  <= 4'h0;
            TX_OBJ_OUT  <= 32'h0;
            BUSY_OUT    <= 1'b0;
            for (int i = 0; i < NUM_BUF; i++) begin
                buf_id[i]    <= ID_RST;
                buf_state[i] <= BUF_OFF;
            end
        end else begin
            state       <= next_state;
            cnt         <= next_cnt;
            obj         <= next_obj;
            copy_sel    <= next_copy_sel;
            pending     <= next_pending;
            sched_valid <= next_sched_valid;
            sched_buf   <= next_sched_buf;
            gap         <= next_gap;
            late        <= next_late;
            last_tx     <= next_last_tx;
            echo_valid  <= next_echo_valid;
            echo_obj    <= next_echo_obj;
            TX_REQ_OUT  <= next_tx_req;
            TX_BUF_OUT  <= next_tx_buf;
            TX_OBJ_OUT  <= next_tx_obj;
            BUSY_OUT    <= next_busy;
            for (int i = 0; i < NUM_BUF; i++) begin
                buf_id[i]    <= next_buf_id[i];
                buf_state[i] <= next_buf_state[i];
            end
        end
    end

endmodule // canbrr_top

// >>> testbench/canbrr_sva.sv
/* Port checker for canbrr_top: APB answer timing, frame engine pacing, bit ticks.
   Assumes one clock domain and binding to canbrr_top. */
`timescale 1ns/1ps
module canbrr_sva (
    input wire logic        CLK_IN,
    input wire logic        RSTN_IN,
    input wire logic        PSEL_IN,
    input wire logic        PENABLE_IN,
    input wire logic        PREADY_OUT,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic        PSLVERR_OUT,
    input wire logic        TX_REQ_OUT,
    input wire logic [31:0] TX_OBJ_OUT,
    input wire logic        SAMPLE_TICK_OUT,
    input wire logic        BIT_TICK_OUT,
    input wire logic        BUSY_OUT
);
    logic [7:0] busy_cnt;
    logic [7:0] next_busy_cnt;
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RSTN_IN);
    // Length of the current busy stretch, saturating.
    always_comb begin
        next_busy_cnt = BUSY_OUT ? ((&busy_cnt) ? busy_cnt : busy_cnt + 8'h01) : 8'h00;
    end
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            busy_cnt <= 8'h00;
        end else begin
            busy_cnt <= next_busy_cnt;
        end
    end
    a_ready_after_setup: assert property (PSEL_IN && !PENABLE_IN |=> PREADY_OUT)
        else $error("ready missing after setup");
    a_ready_one_cycle: assert property (PREADY_OUT |=> !PREADY_OUT)
        else $error("ready held too long");
    a_error_with_ready: assert property (PSLVERR_OUT |-> PREADY_OUT && PRDATA_OUT == 32'h0)
        else $error("error response malformed");
    a_reply_clears_rtr: assert property (TX_REQ_OUT |-> !TX_OBJ_OUT[0])
        else $error("reply keeps remote bit");
    a_sched_once: assert property (TX_REQ_OUT |=> !TX_REQ_OUT [*8])
        else $error("second schedule too soon");
    a_proc_min_time: assert property (TX_REQ_OUT |-> busy_cnt >= 8'd5)
        else $error("processing shorter than update plus schedule");
    a_proc_bounded: assert property ($rose(BUSY_OUT) |-> ##[1:80] !BUSY_OUT)
        else $error("processing too long");
    a_bit_min_len: assert property (BIT_TICK_OUT |=> !BIT_TICK_OUT [*7])
        else $error("bit shorter than eight clocks");
    a_sample_in_bit: assert property (SAMPLE_TICK_OUT |-> !BIT_TICK_OUT)
        else $error("sample point on bit end");
    c_reply: cover property (TX_REQ_OUT);
    c_slverr: cover property (PSLVERR_OUT);
    c_sample: cover property (SAMPLE_TICK_OUT);
endmodule // canbrr_sva
bind canbrr_top canbrr_sva u_sva (.CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
    .PREADY_OUT(PREADY_OUT), .PRDATA_OUT(PRDATA_OUT), .PSLVERR_OUT(PSLVERR_OUT), .TX_REQ_OUT(TX_REQ_OUT),
    .TX_OBJ_OUT(TX_OBJ_OUT), .SAMPLE_TICK_OUT(SAMPLE_TICK_OUT), .BIT_TICK_OUT(BIT_TICK_OUT), .BUSY_OUT(BUSY_OUT));

// >>> testbench/canbrr_node_model.sv
/* Far-side node model: turns a send request into one frame validation pulse.
   Assumes the bench spaces requests past the end of processing. */
`timescale 1ns/1ps
module canbrr_node_model (
    input  wire logic        clk_in,
    input  wire logic        rstn_in,
    input  wire logic        send_in,
    input  wire logic        own_in,
    input  wire logic [31:0] obj_in,
    output logic             frame_valid_out,
    output logic             frame_own_out,
    output logic [31:0]      frame_obj_out
);
    // frames spaced by the bench; between pulses the lines invert each cycle, so stale data matches on every other cycle only.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            frame_valid_out <= 1'b0;
            frame_own_out   <= 1'b0;
            frame_obj_out   <= 32'h0;
        end else begin
            frame_valid_out <= send_in;
            frame_own_out   <= send_in ? own_in : ~frame_own_out;
            frame_obj_out   <= send_in ? obj_in : ~frame_obj_out;
        end
    end
endmodule // canbrr_node_model

// >>> testbench/tb.sv
/* Self-checking bench for canbrr_top with an APB master and the node model.
   Assumes the checker binds itself to the design. */
`timescale 1ns/1ps
module tb;
    import canbrr_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel, penable, pwrite, send, own, e;
    logic        pready, pslverr, fv, fown, tx_req, s_tick, b_tick, busy;
    logic [7:0]  paddr;
    logic [3:0]  tx_buf;
    logic [31:0] pwdata, prdata, fo, fobj, tx_obj, q, rid, xid;
    integer      seed;
    int          num_errors, n_tests, n, na, i, p, s1, s2;
    time         t0;
    canbrr_top u_dut (.CLK_IN(clk), .RSTN_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
        .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PREADY_OUT(pready), .PRDATA_OUT(prdata), .PSLVERR_OUT(pslverr),
        .FRAME_VALID_IN(fv), .FRAME_OWN_IN(fown), .FRAME_OBJ_IN(fobj), .TX_REQ_OUT(tx_req), .TX_BUF_OUT(tx_buf),
        .TX_OBJ_OUT(tx_obj), .SAMPLE_TICK_OUT(s_tick), .BIT_TICK_OUT(b_tick), .BUSY_OUT(busy));
    canbrr_node_model u_node (.clk_in(clk), .rstn_in(rst_n), .send_in(send), .own_in(own), .obj_in(fo),
        .frame_valid_out(fv), .frame_own_out(fown), .frame_obj_out(fobj));
    initial begin
        forever #50 clk = ~clk;
    end
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic tmo();
        num_errors++;
        conclude();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (k == 20) tmo();
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic setb(input int b, input logic [31:0] id, input int st);
        apb(1'b1, 8'(8'h40 + 4 * b), id);
        apb(1'b1, 8'(8'h80 + 4 * b), 32'(st));
    endtask
    task automatic frm(input logic [31:0] o, input logic w);
        send <= 1'b1;
        fo <= o;
        own <= w;
        for (n = 1; n < 90; n++) begin
            @(posedge clk);
            send <= 1'b0;
            if (tx_req === 1'b1 || (n > 3 && busy === 1'b0)) break;
        end
        if (n == 90) tmo();
    endtask
    task automatic wait_tick(input logic smp);
        int k;
        for (k = 0; k < 400; k++) begin
            @(posedge clk);
            if ((smp ? s_tick : b_tick) === 1'b1) break;
        end
        if (k == 400) tmo();
    endtask
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        send = 1'b0;
        own = 1'b0;
        fo = 32'h0;
        num_errors = 0;
        n_tests = 0;
        seed = 32'h8b6ef84b;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        apb(1'b0, ADDR_TIMING, 32'h0);
        chk(q, 32'h40); // timing after reset
        apb(1'b0, 8'hfc, 32'h0);
        chk({31'h0, e}, 32'h1);
        chk(q, 32'h0);
        $display("Test registers done");
        apb(1'b1, ADDR_GMASK, 32'h1); // remote bit ignored
        apb(1'b1, ADDR_CTRL, 32'h1);
        rid = $random(seed) & 32'hfffffffe;
        for (na = 1; na < 4; na += 2) begin
            setb(0, rid, 1);
            for (i = 1; i <= na; i++) setb(i, rid, 4);
            fork
                frm(rid | 32'h1, 1'b0);
                if (na == 3) begin
                    repeat (5) @(posedge clk);
                    apb(1'b0, 8'h44, 32'h0);
                    chk(q, rid); // buffer read during processing
                end
            join
            chk(32'(n), 32'(3 + 17 + 3 * na + 2 + ((na == 3) ? 2 : 0))); // copy, updates, schedule, stall
            chk(tx_obj, rid); // data reply
            chk(32'(tx_buf), 32'h1); // lowest reply buffer scheduled
            apb(1'b0, 8'h80, 32'h0);
            chk(q, 32'h2); // copied buffer full
            apb(1'b0, 8'h40, 32'h0);
            chk(q, rid | 32'h1); // object copied
            apb(1'b0, 8'(8'h80 + 4 * na), 32'h0);
            chk(q, 32'h5); // single reply state
        end
        $display("Test remote reply done");
        xid = rid ^ 32'h100;
        setb(4, xid, 1);
        setb(5, xid, 1);
        frm(xid, 1'b0);
        frm(xid ^ 32'h200, 1'b0);
        frm(xid, 1'b1);
        apb(1'b0, 8'h94, 32'h0);
        chk(q, 32'h1); // differing frame prevents copy
        setb(4, xid, 1);
        frm(xid, 1'b0);
        frm(xid, 1'b1);
        apb(1'b0, 8'h94, 32'h0);
        chk(q, 32'h2); // own frame copied
        $display("Test self reception done");
        for (i = 0; i < 4; i++) begin
            p = (i == 3) ? 0 : ($random(seed) & 7);
            s1 = (i == 3) ? 1 : ($random(seed) & 7);
            s2 = (i == 3) ? 0 : ($random(seed) & 7);
            apb(1'b1, ADDR_CTRL, 32'h0);
            apb(1'b1, ADDR_TIMING, 32'(p + s1 * 64 + s2 * 1024));
            apb(1'b1, ADDR_CTRL, 32'h1);
            wait_tick(1'b0);
            t0 = $time;
            wait_tick(1'b1);
            chk(32'(($time - t0) / 100), 32'((p + 2) * (s1 + 2))); // sample point
            wait_tick(1'b0);
            chk(32'(($time - t0) / 100), 32'((p + 2) * (1 + s1 + 1 + s2 + 1))); // bit length
        end
        $display("Test bit timing done");
        conclude();
    end
endmodule // tb
